// >>> hw/dis_pkg.sv
// Package for the discrete input and status logic: constants and types
package dis_pkg;
    // Number of discrete inputs
    localparam int NUM_IN = 3;
    // Encoder position width
    localparam int POS_W = 32;
    // Wishbone address and data widths
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    // Register byte offsets
    localparam logic [7:0] REG_CFG0 = 8'h00; // Config for input 0
    localparam logic [7:0] REG_CFG1 = 8'h04; // Config for input 1
    localparam logic [7:0] REG_CFG2 = 8'h08; // Config for input 2
    localparam logic [7:0] REG_STATUS = 8'h0C; // Input and motion status
    localparam logic [7:0] REG_CAPPOS = 8'h10; // Captured encoder position
    localparam logic [7:0] REG_INDOR = 8'h14; // Indicator control
    // Config field positions: function in [2:0], active-low in [3]
    localparam int CFG_FUNC_LSB = 0;
    localparam int CFG_POL_BIT = 3;
    // Indicator control fields
    localparam int IND_NSMODE_BIT = 0; // 1 selects Modbus TCP patterns
    localparam int IND_NSCODE_LSB = 4; // 3-bit network state code
    localparam int IND_CONN_LSB = 8; // 2-bit open connection count
    localparam int IND_FLASHOK_BIT = 12; // Flash write succeeded
    localparam int IND_FLASHBAD_BIT = 13; // Flash write failed
    // Reset values
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam logic [2:0] CONN_MAX = 3'h3; // Most concurrent connections
    // Timing: clock and indicator periods
    localparam int CLK_HZ = 10_000_000;
    localparam int BLINK_MS = 250; // Blink half-period
    localparam int PAUSE_MS = 2000; // Pause between connection groups
    localparam int FILT_US = 100; // Input filter time
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int FILT_CYC = CLK_HZ / 1_000_000 * FILT_US;
    localparam int PAUSE_TICKS = PAUSE_MS / BLINK_MS;
    // Input functions
    typedef enum logic [2:0] {
        DIS_FN_GP = 3'b000,
        DIS_FN_HOME = 3'b001,
        DIS_FN_CWLIM = 3'b010,
        DIS_FN_CCWLIM = 3'b011,
        DIS_FN_START = 3'b100,
        DIS_FN_ESTOP = 3'b101,
        DIS_FN_STOPJOG = 3'b110
    } dis_func_t;
    // Network status codes, industrial-protocol mode
    typedef enum logic [2:0] {
        DIS_NS_OFF = 3'b000,
        DIS_NS_SELFTEST = 3'b001,
        DIS_NS_LINK = 3'b010,
        DIS_NS_CONN = 3'b011,
        DIS_NS_TIMEOUT = 3'b100,
        DIS_NS_DUPIP = 3'b101
    } dis_ns_t;
    // Module status pattern state
    typedef enum logic [2:0] {
        DIS_MS_OK = 3'b000,
        DIS_MS_OVERTEMP = 3'b001,
        DIS_MS_FLASHOK = 3'b010,
        DIS_MS_FLASHBAD = 3'b011,
        DIS_MS_COMFAIL = 3'b100
    } dis_ms_t;
    // Bi-colour indicator drive
    typedef struct packed {
        logic red;
        logic green;
    } dis_led_t;
    // Motion requests from the sequencer
    typedef struct packed {
        logic moveReq; // Start a non-indexer move
        logic moveDirCw; // Requested direction clockwise
        logic moveIsJog; // Move is jog or registration
        logic indexArm; // Load a pending indexer move
        logic homeCmd; // Host homing command
    } dis_mreq_t;
    // Motion commands to the sequencer
    typedef struct packed {
        logic haltNow; // Stop all motion at once
        logic decelStop; // Controlled stop
        logic startMove; // Start granted
        logic startIndex; // Pending indexer move started
        logic homeSearch; // Search home sensor
        logic drvEnable; // Driver enable
    } dis_mcmd_t;
endpackage : dis_pkg

// >>> hw/dis_input_status.sv
// Discrete input functions, position capture and status indicators
// Functional notes
// - Each input has programmable active level
// - CW limit during CW motion halts
// - At a limit, only move away (indexer start and home search are not limit-checked here)
// - Indexer move starts on start-input edge
// - Start input latches position both edges
// - Emergency stop halts motion at once
// - Driver stays enabled after emergency stop
// - No move starts while emergency stop active (home search is not blocked by it here)
// - Stop input decelerates jog or registration
// - Stop input ignored by other moves
// - Stop input latches position during jog
// - General purpose inputs reported, no motion
// - Homing commands search the home input
// - Module status green OK, red overtemperature
// - Flash success blinks green, locks commands
// - Flash failure blinks red until power cycle
// - Coprocessor failure alternates red and green
// - Six network patterns in industrial mode
// - Modbus mode flashes per connection, pauses
// - Link indicator lit while link present
// - Link indicator flashes during transmit
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module dis_input_status
    import dis_pkg::*;
(
    input wire logic mclk, // System clock, 10 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic [dis_pkg::ADR_W-1:0] wb_adr_i, // Wishbone address
    input wire logic [dis_pkg::DAT_W-1:0] wb_dat_i, // Wishbone write data
    output logic [dis_pkg::DAT_W-1:0] wb_dat_o, // Wishbone read data
    input wire logic [3:0] wb_sel_i, // Wishbone byte enables
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic [dis_pkg::NUM_IN-1:0] inPin, // Raw discrete inputs
    input wire logic encFitted, // Encoder option present
    input wire logic [dis_pkg::POS_W-1:0] encPos, // Encoder position
    input wire dis_pkg::dis_mreq_t mreq, // Sequencer requests
    input wire logic motionCw, // Motor turning clockwise
    input wire logic motionCcw, // Motor turning counter-clockwise
    input wire logic jogActive, // Jog or registration running
    input wire logic overTemp, // Overtemperature fault
    input wire logic comFail, // Coprocessor link failure
    input wire logic hostCmd, // Host command arrives
    input wire logic linkUp, // Physical Ethernet link
    input wire logic txActive, // Ethernet transmitting
    output dis_pkg::dis_mcmd_t mcmd, // Motion commands
    output logic hostCmdOk, // Host command accepted pulse
    output logic [dis_pkg::NUM_IN-1:0] gpState, // General purpose states
    output logic capStrobe, // Position captured pulse
    output dis_pkg::dis_led_t module_status_indicator, // Module LED
    output dis_pkg::dis_led_t network_status_indicator, // Network LED
    output logic linkLed // Link LED
);
    import dis_pkg::*;

    // Per-input configuration registers
    logic [3:0] cfg_ff [NUM_IN];
    // Three-stage synchroniser and filter state
    logic [NUM_IN-1:0] syncA_ff, syncB_ff, syncC_ff;
    logic [NUM_IN-1:0] filt_ff; // Filtered raw level
    logic [15:0] filtCnt_ff [NUM_IN]; // Filter counters
    logic [NUM_IN-1:0] act_ff; // Active after polarity
    logic [NUM_IN-1:0] actRise, actFall; // Edges of active level
    // Function decode per input
    logic [NUM_IN-1:0] isCw, isCcw, isStart, isEstop, isStop, isGp, isHome;

    // Synchronise, filter and apply polarity per input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            // Two and three agree before the filter sees a change
            always_ff @(posedge mclk) begin
                if (reset) begin
                    syncA_ff[gi] <= 1'b0;
                    syncB_ff[gi] <= 1'b0;
                    syncC_ff[gi] <= 1'b0;
                    filt_ff[gi] <= 1'b0;
                    filtCnt_ff[gi] <= 16'h0000;
                end else begin
                    syncA_ff[gi] <= inPin[gi];
                    syncB_ff[gi] <= syncA_ff[gi];
                    syncC_ff[gi] <= syncB_ff[gi];
                    if (syncB_ff[gi] != syncC_ff[gi] ||
                        syncC_ff[gi] == filt_ff[gi]) begin
                        filtCnt_ff[gi] <= 16'h0000; // Unstable or equal
                    end else if (filtCnt_ff[gi] == 16'(FILT_CYC - 1)) begin
                        filt_ff[gi] <= syncC_ff[gi]; // Stable long enough
                        filtCnt_ff[gi] <= 16'h0000;
                    end else begin
                        filtCnt_ff[gi] <= filtCnt_ff[gi] + 16'h0001;
                    end
                end
            end
            // Active level after programmable inversion
            always_ff @(posedge mclk) begin
                if (reset) begin
                    act_ff[gi] <= 1'b0;
                end else begin
                    act_ff[gi] <= filt_ff[gi] ^
                        cfg_ff[gi][CFG_POL_BIT];
                end
            end
            assign actRise[gi] = (filt_ff[gi] ^ cfg_ff[gi][CFG_POL_BIT]) &
                                 ~act_ff[gi];
            assign actFall[gi] = ~(filt_ff[gi] ^ cfg_ff[gi][CFG_POL_BIT]) &
                                 act_ff[gi];
            assign isCw[gi] = cfg_ff[gi][2:0] == DIS_FN_CWLIM;
            assign isCcw[gi] = cfg_ff[gi][2:0] == DIS_FN_CCWLIM;
            assign isStart[gi] = cfg_ff[gi][2:0] == DIS_FN_START;
            assign isEstop[gi] = cfg_ff[gi][2:0] == DIS_FN_ESTOP;
            assign isStop[gi] = cfg_ff[gi][2:0] == DIS_FN_STOPJOG;
            assign isGp[gi] = cfg_ff[gi][2:0] == DIS_FN_GP;
            assign isHome[gi] = cfg_ff[gi][2:0] == DIS_FN_HOME;
        end
    endgenerate

    // Combined function levels and edges
    logic cwLim, ccwLim, estop, startRise, startEdge, stopRise, homeSet;
    assign cwLim = |(isCw & act_ff);
    assign ccwLim = |(isCcw & act_ff);
    assign estop = |(isEstop & act_ff);
    assign startRise = |(isStart & actRise);
    assign startEdge = |(isStart & (actRise | actFall));
    assign stopRise = |(isStop & actRise);
    assign homeSet = |isHome;

    // Start of a requested move is allowed
    logic moveAllowed;
    assign moveAllowed = ~estop
        & ~(cwLim & mreq.moveDirCw)
        & ~(ccwLim & ~mreq.moveDirCw);

    // Pending indexer move latch
    logic indexPend_ff;
    always_ff @(posedge mclk) begin
        if (reset) begin
            indexPend_ff <= 1'b0;
        end else if (mreq.indexArm) begin
            indexPend_ff <= 1'b1; // New arm wins over a launch
        end else if (startRise && indexPend_ff && !estop) begin
            indexPend_ff <= 1'b0; // Launched by input edge
        end
    end

    // Motion command outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            mcmd <= '0;
        end else begin
            mcmd.haltNow <= estop
                | (cwLim & motionCw)
                | (ccwLim & motionCcw);
            mcmd.decelStop <= stopRise & jogActive;
            mcmd.startMove <= mreq.moveReq & moveAllowed;
            mcmd.startIndex <= startRise & indexPend_ff & ~estop;
            mcmd.homeSearch <= mreq.homeCmd & homeSet;
            mcmd.drvEnable <= 1'b1;
        end
    end

    // Encoder position capture
    logic [POS_W-1:0] capPos_ff;
    logic capNow;
    assign capNow = encFitted & (startEdge
        | (stopRise & jogActive));
    always_ff @(posedge mclk) begin
        if (reset) begin
            capPos_ff <= '0;
            capStrobe <= 1'b0;
        end else begin
            capStrobe <= capNow;
            if (capNow) begin
                capPos_ff <= encPos;
            end
        end
    end

    // General purpose state reported to host
    always_ff @(posedge mclk) begin
        if (reset) begin
            gpState <= '0;
        end else begin
            gpState <= isGp & act_ff;
        end
    end

    // Indicator control register
    logic [DAT_W-1:0] indCtl_ff;
    logic flashOk_ff, flashBad_ff; // Sticky until power cycle
    // Flash flags are set from control bits; only a reset,
    // standing in for a power cycle, clears them

    // Wishbone slave: one-cycle ack, writes and reads
    logic wbHit;
    assign wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wbHit;
            wb_dat_o <= '0;
            if (wbHit && !wb_we_i) begin
                case (wb_adr_i)
                    REG_CFG0: wb_dat_o <= {28'h000_0000, cfg_ff[0]};
                    REG_CFG1: wb_dat_o <= {28'h000_0000, cfg_ff[1]};
                    REG_CFG2: wb_dat_o <= {28'h000_0000, cfg_ff[2]};
                    REG_STATUS: wb_dat_o <= {20'h0_0000, indexPend_ff,
                        flashBad_ff, flashOk_ff, 2'b00, act_ff,
                        1'b0, filt_ff};
                    REG_CAPPOS: wb_dat_o <= capPos_ff;
                    REG_INDOR: wb_dat_o <= indCtl_ff;
                    default: wb_dat_o <= '0; // Unmapped reads zero
                endcase
            end
        end
    end

    // Configuration writes, low byte lane
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_cfg
            always_ff @(posedge mclk) begin
                if (reset) begin
                    cfg_ff[gi] <= CFG_RESET;
                end else if (wbHit && wb_we_i && wb_sel_i[0] &&
                             wb_adr_i == 8'(gi * 4)) begin
                    cfg_ff[gi] <= wb_dat_i[3:0];
                end
            end
        end
    endgenerate

    // Indicator control write and flash result flags
    always_ff @(posedge mclk) begin
        if (reset) begin
            indCtl_ff <= '0;
        end else if (wbHit && wb_we_i && wb_adr_i == REG_INDOR) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    indCtl_ff[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            flashOk_ff <= 1'b0;
            flashBad_ff <= 1'b0;
        end else begin
            flashOk_ff <= flashOk_ff | indCtl_ff[IND_FLASHOK_BIT];
            flashBad_ff <= flashBad_ff | indCtl_ff[IND_FLASHBAD_BIT];
        end
    end

    // Host commands refused after a successful flash write
    always_ff @(posedge mclk) begin
        if (reset) begin
            hostCmdOk <= 1'b0;
        end else begin
            hostCmdOk <= hostCmd & ~flashOk_ff;
        end
    end

    // Blink tick divider and phase
    logic [23:0] blinkCnt_ff;
    logic blinkTick, phase_ff;
    assign blinkTick = blinkCnt_ff == 24'(BLINK_CYC - 1);
    always_ff @(posedge mclk) begin
        if (reset) begin
            blinkCnt_ff <= 24'h00_0000;
            phase_ff <= 1'b0;
        end else if (blinkTick) begin
            blinkCnt_ff <= 24'h00_0000;
            phase_ff <= ~phase_ff;
        end else begin
            blinkCnt_ff <= blinkCnt_ff + 24'h00_0001;
        end
    end

    // Module status priority and pattern
    dis_ms_t msState;
    always_comb begin
        if (comFail) begin
            msState = DIS_MS_COMFAIL;
        end else if (flashBad_ff) begin
            msState = DIS_MS_FLASHBAD;
        end else if (flashOk_ff) begin
            msState = DIS_MS_FLASHOK;
        end else if (overTemp) begin
            msState = DIS_MS_OVERTEMP;
        end else begin
            msState = DIS_MS_OK;
        end
    end
    logic comFailSeen_ff; // Alternation held until power cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            comFailSeen_ff <= 1'b0;
        end else if (comFail) begin
            comFailSeen_ff <= 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            module_status_indicator <= '0;
        end else if (comFailSeen_ff) begin
            module_status_indicator <= {phase_ff, ~phase_ff};
        end else begin
            case (msState)
                DIS_MS_OVERTEMP: module_status_indicator <= 2'b10;
                DIS_MS_FLASHOK: module_status_indicator <=
                    {1'b0, phase_ff};
                DIS_MS_FLASHBAD: module_status_indicator <=
                    {phase_ff, 1'b0};
                DIS_MS_COMFAIL: module_status_indicator <=
                    {phase_ff, ~phase_ff};
                default: module_status_indicator <= 2'b01;
            endcase
        end
    end

    // Modbus connection flash sequencer: flashes then pause
    logic [3:0] mbStep_ff; // Half-blink steps within group
    logic [2:0] conn;
    assign conn = (indCtl_ff[IND_CONN_LSB +: 2] > CONN_MAX[1:0]) ?
        CONN_MAX : {1'b0, indCtl_ff[IND_CONN_LSB +: 2]};
    always_ff @(posedge mclk) begin
        if (reset) begin
            mbStep_ff <= 4'h0;
        end else if (blinkTick) begin
            if (mbStep_ff >= {conn, 1'b0} + 4'(PAUSE_TICKS) - 4'h1) begin
                mbStep_ff <= 4'h0;
            end else begin
                mbStep_ff <= mbStep_ff + 4'h1;
            end
        end
    end

    // Network status pattern
    always_ff @(posedge mclk) begin
        if (reset) begin
            network_status_indicator <= '0;
        end else if (indCtl_ff[IND_NSMODE_BIT]) begin
            network_status_indicator <= {1'b0,
                (mbStep_ff < {conn, 1'b0}) & ~mbStep_ff[0]};
        end else begin
            case (indCtl_ff[IND_NSCODE_LSB +: 3])
                DIS_NS_SELFTEST: network_status_indicator <=
                    {phase_ff, ~phase_ff};
                DIS_NS_LINK: network_status_indicator <= {1'b0, phase_ff};
                DIS_NS_CONN: network_status_indicator <= 2'b01;
                DIS_NS_TIMEOUT: network_status_indicator <= {phase_ff, 1'b0};
                DIS_NS_DUPIP: network_status_indicator <= 2'b10;
                default: network_status_indicator <= 2'b00;
            endcase
        end
    end

    // Link indicator: on with link, flashing while sending
    always_ff @(posedge mclk) begin
        if (reset) begin
            linkLed <= 1'b0;
        end else begin
            linkLed <= linkUp & ~(txActive & phase_ff);
        end
    end
endmodule : dis_input_status
`default_nettype wire

// >>> test/dis_input_status_sva.sv
// Port-level checker for the input and status block
`timescale 1ns/1ps
`default_nettype none
module dis_input_status_sva
    import dis_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic reset, // Reset
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_ack_o, // Bus acknowledge
    input wire logic [dis_pkg::DAT_W-1:0] wb_dat_o, // Read data
    input wire dis_pkg::dis_mreq_t mreq, // Sequencer requests
    input wire dis_pkg::dis_mcmd_t mcmd, // Motion commands
    input wire logic capStrobe, // Capture pulse
    input wire logic hostCmd, // Host command
    input wire logic hostCmdOk, // Host command accepted
    input wire logic linkUp, // Physical link
    input wire logic txActive, // Transmitting
    input wire logic linkLed // Link light
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Bus answers exactly one cycle after take
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) // Bus handshake
        else $error("ack late");
    // Ack lasts one cycle
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) // Bus handshake
        else $error("ack too long");
    // Read data is zero outside the ack cycle
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == '0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) // Bus handshake
        else $error("read data not idle");
    // Driver stays enabled in all states
    property p_drv_on;
        !$past(reset) |-> mcmd.drvEnable;
    endproperty
    a_drv_on: assert property (p_drv_on)
        else $error("driver disabled");
    // A granted start needs a request
    property p_start_req;
        mcmd.startMove |-> $past(mreq.moveReq);
    endproperty
    a_start_req: assert property (p_start_req)
        else $error("start without request");
    // Capture strobe is a single pulse
    property p_cap_pulse;
        capStrobe |=> !capStrobe;
    endproperty
    a_cap_pulse: assert property (p_cap_pulse)
        else $error("capture pulse too long");
    // Accepted command follows a host command
    property p_cmd_ok;
        hostCmdOk |-> $past(hostCmd);
    endproperty
    a_cmd_ok: assert property (p_cmd_ok)
        else $error("accept without command");
    // No link, no light
    property p_link_off;
        !linkUp |=> !linkLed;
    endproperty
    a_link_off: assert property (p_link_off)
        else $error("link light without link");
    // Idle link shows steady light
    property p_link_on;
        linkUp && !txActive |=> linkLed;
    endproperty
    a_link_on: assert property (p_link_on)
        else $error("link light off");
endmodule : dis_input_status_sva
bind dis_input_status dis_input_status_sva u_sva (.mclk, .reset,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .mreq, .mcmd, .capStrobe,
    .hostCmd, .hostCmdOk, .linkUp, .txActive, .linkLed);
`default_nettype wire

// >>> test/dis_field_model.sv
// Field sensor model: level that each contact puts on its pin
`timescale 1ns/1ps
`default_nettype none
module dis_field_model
    import dis_pkg::*;
(
    input wire logic [dis_pkg::NUM_IN-1:0] sensAct, // Sensor engaged
    input wire logic [dis_pkg::NUM_IN-1:0] actLow, // Normally closed
    output logic [dis_pkg::NUM_IN-1:0] pinLvl // Level at the pin
);
    // Closed contact wiring inverts the engaged level
    assign pinLvl = sensAct ^ actLow;
endmodule : dis_field_model
`default_nettype wire

// >>> test/test_discrete_input_and_status_logic.sv
// Self-checking bench for the input and status block
`timescale 1ns/1ps
`default_nettype none
module test_discrete_input_and_status_logic;
    import dis_pkg::*;
    logic mclk, reset, we, cyc, stb, ack, encFitted, motionCw, jogActive;
    logic overTemp, hostCmd, linkUp, hostCmdOk, capStrobe, linkLed, comFail;
    logic [7:0] adr;
    logic [31:0] datW, datR, encPos;
    logic [2:0] sensAct, actLow, inPin, gpState;
    dis_mreq_t mreq;
    dis_mcmd_t mcmd;
    dis_led_t msLed, nsLed;
    logic [31:0] expQ[$]; // Expected read words
    int n_mismatch = 0;
    int compares = 0;
    // Clock, 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    dis_field_model field (.sensAct(sensAct), .actLow(actLow),
        .pinLvl(inPin));
    dis_input_status uut (.mclk(mclk), .reset(reset), .wb_adr_i(adr),
        .wb_dat_i(datW), .wb_dat_o(datR), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .inPin(inPin),
        .encFitted(encFitted), .encPos(encPos), .mreq(mreq),
        .motionCw(motionCw), .motionCcw(1'b0), .jogActive(jogActive),
        .overTemp(overTemp), .comFail(comFail), .hostCmd(hostCmd),
        .linkUp(linkUp), .txActive(1'b0), .mcmd(mcmd),
        .hostCmdOk(hostCmdOk), .gpState(gpState), .capStrobe(capStrobe),
        .module_status_indicator(msLed), .network_status_indicator(nsLed),
        .linkLed(linkLed));
    // Verdict and end of run
    task summarize;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // Compare one value
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Read results taken against the oldest note
    always @(posedge mclk) begin
        if (ack === 1'b1 && !we) begin
            chk("rdata", expQ.size() ? expQ.pop_front() : '1, datR);
        end
    end
    // One classic bus cycle, held until ack
    task wbAcc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask : wbAcc
    task wbRd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        wbAcc(1'b0, a, 32'h0000_0000);
    endtask : wbRd
    // Let an input change pass the filter
    task settle;
        repeat (1012) @(posedge mclk);
    endtask : settle
    // Wait for a capture pulse, bounded
    task waitCap;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (capStrobe !== 1'b1 && n < 1200);
        if (capStrobe !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask : waitCap
    // Let a registered command settle
    task two;
        repeat (2) @(posedge mclk);
    endtask : two
    // Main sequence
    initial begin
        reset = 1'b1;
        {cyc, stb, we, adr, datW, encPos, mreq} = '0;
        {motionCw, jogActive, overTemp, hostCmd, linkUp, comFail} = '0;
        {sensAct, actLow} = '0;
        encFitted = 1'b1;
        void'($urandom(68348));
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        two();
        chk("drvEn", 1, mcmd.drvEnable);
        chk("msLed", 1, msLed);
        wbRd(REG_CFG0, 32'h0000_0000);
        wbRd(8'h1C, 32'h0000_0000);
        // Clockwise limit wired normally closed
        actLow[0] <= 1'b1;
        wbAcc(1'b1, REG_CFG0, 32'h0000_000A);
        settle();
        motionCw <= 1'b1;
        sensAct[0] <= 1'b1;
        settle();
        chk("haltCw", 1, mcmd.haltNow);
        wbRd(REG_STATUS, 32'h0000_0010);
        mreq <= 5'b11000;
        two();
        chk("startToward", 0, mcmd.startMove);
        mreq <= 5'b10000;
        two();
        chk("startAway", 1, mcmd.startMove);
        {mreq, motionCw, sensAct[0]} <= '0;
        settle();
        // Emergency stop blocks even a jog
        wbAcc(1'b1, REG_CFG1, 32'h0000_0005);
        sensAct[1] <= 1'b1;
        settle();
        chk("haltEstop", 1, mcmd.haltNow);
        chk("drvEstop", 1, mcmd.drvEnable);
        mreq <= 5'b10100;
        two();
        chk("startEstop", 0, mcmd.startMove);
        {mreq, sensAct[1]} <= '0;
        settle();
        // Start input: pending move and capture on both edges
        wbAcc(1'b1, REG_CFG2, 32'h0000_0004);
        mreq <= 5'b00010;
        encPos <= $urandom;
        @(posedge mclk);
        mreq <= '0;
        sensAct[2] <= 1'b1;
        waitCap();
        chk("idxRise", 1, mcmd.startIndex);
        wbRd(REG_CAPPOS, encPos);
        encPos <= $urandom;
        sensAct[2] <= 1'b0;
        waitCap();
        chk("idxFall", 0, mcmd.startIndex);
        wbRd(REG_CAPPOS, encPos);
        // Stop input ends a jog with a controlled stop
        wbAcc(1'b1, REG_CFG2, 32'h0000_0006);
        jogActive <= 1'b1;
        sensAct[2] <= 1'b1;
        waitCap();
        chk("decel", 1, mcmd.decelStop);
        // General purpose input reported, motion untouched
        wbAcc(1'b1, REG_CFG0, 32'h0000_0008);
        {motionCw, sensAct[0]} <= 2'b11;
        settle();
        chk("gpState", 3'b001, gpState);
        chk("gpHalt", 0, mcmd.haltNow);
        // Homing needs an input with the home function
        mreq <= 5'b00001;
        two();
        chk("homeNone", 0, mcmd.homeSearch);
        wbAcc(1'b1, REG_CFG1, 32'h0000_0001);
        chk("homeSeek", 1, mcmd.homeSearch);
        mreq <= '0;
        // Indicators
        overTemp <= 1'b1;
        linkUp <= 1'b1;
        hostCmd <= 1'b1;
        two();
        chk("msRed", 2, msLed);
        chk("linkLed", 1, linkLed);
        chk("cmdOk", 1, hostCmdOk);
        hostCmd <= 1'b0;
        wbAcc(1'b1, REG_INDOR, 32'h0000_0050);
        chk("nsDupIp", 2, nsLed);
        wbAcc(1'b1, REG_INDOR, 32'h0000_0030);
        chk("nsConn", 1, nsLed);
        // Flash success locks host commands
        hostCmd <= 1'b1;
        wbAcc(1'b1, REG_INDOR, 32'h0000_1000);
        two();
        chk("cmdLock", 0, hostCmdOk);
        chk("nsOff", 0, nsLed);
        // A single failure pulse latches the alternating pattern
        comFail <= 1'b1;
        @(posedge mclk);
        comFail <= 1'b0;
        two();
        chk("msComFail", 1, msLed);
        summarize();
    end
endmodule : test_discrete_input_and_status_logic
`default_nettype wire
